// ### stack_io_regs.svh
// register offsets, opcodes, state counts and field positions of the stack/io/control executor
`ifndef STACK_IO_REGS_SVH
`define STACK_IO_REGS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFF_CMD 32'h0000_0000
`define OFF_STATUS 32'h0000_0004
`define OFF_BC 32'h0000_0008
`define OFF_DE 32'h0000_000C
`define OFF_HL 32'h0000_0010
`define OFF_AF 32'h0000_0014
`define OFF_SP 32'h0000_0018
// ****************************************
// status register bits
// ****************************************
`define STAT_BUSY 0
`define STAT_HALTED 1
`define STAT_IRQ_EN 2
`define STAT_EI_PEND 3
`define STAT_BAD_OP 4
// ****************************************
// opcodes handled here
// ****************************************
`define OP_PUSH_MASK 8'hCF
`define OP_PUSH 8'hC5
`define OP_POP 8'hC1
`define OP_SWAP_TOP 8'hE3
`define OP_LOAD_SP 8'hF9
`define OP_IN 8'hDB
`define OP_OUT 8'hD3
`define OP_EI 8'hFB
`define OP_DI 8'hF3
`define OP_STOP 8'h76
`define OP_IDLE 8'h00
// ****************************************
// states per instruction, one clock each
// ****************************************
`define ST_PUSH 5'h0B
`define ST_POP 5'h0A
`define ST_SWAP 5'h12
`define ST_LOAD_SP 5'h05
`define ST_IO 5'h0A
`define ST_SHORT 5'h04
`define ST_STOP 5'h07
`define ST_BAD 5'h01
// bus access slots, counted in states from the first state
`define SLOT_A 5'h04
`define SLOT_B 5'h07
`define SLOT_C 5'h0A
`define SLOT_D 5'h0D
// ****************************************
// flag byte layout and bus answers
// ****************************************
`define FB_SIGN 7
`define FB_ZERO 6
`define FB_ZERO5 5
`define FB_AUX 4
`define FB_ZERO3 3
`define FB_PARITY 2
`define FB_ONE1 1
`define FB_CARRY 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SP_STEP 16'h0002
`define ONE16 16'h0001
`endif

// ### stack_io_pkg.sv
// types shared by the stack/io/control executor
package stack_io_pkg;
  // executor sequence, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_RUN = 3'h2,
    S_HALT = 3'h4
  } exec_state_t;
  // pair select field codes
  typedef enum logic [1:0] {
    PAIR_BC = 2'h0,
    PAIR_DE = 2'h1,
    PAIR_HL = 2'h2,
    PAIR_STATUS = 2'h3
  } pair_t;
endpackage

// ### flag_word_codec.sv
// packs the condition flags into the status byte and unpacks a byte back into flags
`timescale 1ns/1ps
`include "stack_io_regs.svh"
module flag_word_codec (
  // flags to pack
  input wire logic sign_in,
  input wire logic zero_in,
  input wire logic aux_in,
  input wire logic parity_in,
  input wire logic carry_in,
  output logic [7:0] packed_byte,
  // byte to unpack
  input wire logic [7:0] unpack_byte,
  output logic sign_out,
  output logic zero_out,
  output logic aux_out,
  output logic parity_out,
  output logic carry_out
);
  // ****************************************
  // packing with fixed constant bits
  // ****************************************
  always_comb begin
    packed_byte = 8'h00;
    packed_byte[`FB_SIGN] = sign_in;
    packed_byte[`FB_ZERO] = zero_in;
    packed_byte[`FB_ZERO5] = 1'b0;
    packed_byte[`FB_AUX] = aux_in;
    packed_byte[`FB_ZERO3] = 1'b0;
    packed_byte[`FB_PARITY] = parity_in;
    packed_byte[`FB_ONE1] = 1'b1;
    packed_byte[`FB_CARRY] = carry_in;
  end
  // unpacking ignores the constant bits
  assign sign_out = unpack_byte[`FB_SIGN];
  assign zero_out = unpack_byte[`FB_ZERO];
  assign aux_out = unpack_byte[`FB_AUX];
  assign parity_out = unpack_byte[`FB_PARITY];
  assign carry_out = unpack_byte[`FB_CARRY];
endmodule

// ### stack_io_exec.sv
// executor for stack, port and machine-control instructions with an axi4-lite register port
// What this block does
// - push pair: high at sp-1, low at sp-2
// - pair field never selects the stack pointer
// - push status: accumulator sp-1, flags sp-2
// - pop pair: low from sp, high sp+1
// - pop status: flags from sp, accumulator sp+1
// - swap stack top with hl, 18 states
// - load stack pointer from hl, 5 states
// - port input into accumulator, 10 states
// - port output drives accumulator, 10 states
// - enable takes effect after next instruction
// - disable turns interrupts off immediately
// - stop halts, registers unchanged, 7 states
// - idle does nothing, 4 states
// - only status pop and software writes to the AF register change the flags
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "stack_io_regs.svh"
module stack_io_exec (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory and port bus
  output logic [15:0] bus_addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic mem_rd,
  output logic mem_wr,
  output logic io_rd,
  output logic io_wr,
  // interrupt acceptance level
  output logic irq_enabled
);
  import stack_io_pkg::*;
  // ****************************************
  // decode helpers
  // ****************************************
  // true for mapped register offsets
  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a == `OFF_CMD) || (a == `OFF_STATUS) || (a == `OFF_BC) || (a == `OFF_DE) ||
              (a == `OFF_HL) || (a == `OFF_AF) || (a == `OFF_SP);
  endfunction
  // push with any pair code
  function automatic logic is_push(input logic [7:0] o);
    is_push = (o & `OP_PUSH_MASK) == `OP_PUSH;
  endfunction
  // pop with any pair code
  function automatic logic is_pop(input logic [7:0] o);
    is_pop = (o & `OP_PUSH_MASK) == `OP_POP;
  endfunction
  // number of states an opcode runs
  function automatic logic [4:0] op_states(input logic [7:0] o);
    if (is_push(o)) begin
      op_states = `ST_PUSH;
    end else if (is_pop(o)) begin
      op_states = `ST_POP;
    end else begin
      case (o)
        `OP_SWAP_TOP: op_states = `ST_SWAP;
        `OP_LOAD_SP: op_states = `ST_LOAD_SP;
        `OP_IN, `OP_OUT: op_states = `ST_IO;
        `OP_EI, `OP_DI, `OP_IDLE: op_states = `ST_SHORT;
        `OP_STOP: op_states = `ST_STOP;
        default: op_states = `ST_BAD;
      endcase
    end
  endfunction
  // merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction
  // ****************************************
  // state
  // ****************************************
  logic aw_full, w_full; // write halves held
  logic [31:0] aw_addr, w_data; // held write address and data
  logic [3:0] w_strb; // held byte enables
  logic next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic [31:0] next_aw_addr, next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  exec_state_t state, next_state; // executor sequence
  logic [4:0] cnt, next_cnt; // state within instruction
  logic [7:0] op, next_op; // opcode being run
  logic [7:0] port, next_port; // port number operand
  logic [7:0] b, c, d, e, h, l, acc; // register file
  logic [7:0] next_b, next_c, next_d, next_e, next_h, next_l, next_acc;
  logic [15:0] sp, next_sp; // stack_pointer
  logic fs, fz, fac, fp, fcy; // sign, zero, aux_carry_flag, parity, carry_flag
  logic next_fs, next_fz, next_fac, next_fp, next_fcy;
  logic ie, next_ie; // interrupt enable bit
  logic ei_pend, next_ei_pend; // delayed enable pending
  logic bad_op, next_bad_op; // sticky unsupported opcode
  logic [7:0] tmp_lo, tmp_hi, next_tmp_lo, next_tmp_hi; // bytes read from the bus
  logic [15:0] next_bus_addr;
  logic [7:0] next_data_out;
  logic next_data_oe, next_mem_rd, next_mem_wr, next_io_rd, next_io_wr;
  // ****************************************
  // combinational decode
  // ****************************************
  logic wr_fire, ar_fire, start, done, busy, wr_ok, wr_af;
  logic [4:0] slot; // state index of the coming cycle
  logic [7:0] flag_byte, pair_hi, pair_lo, unpack_src;
  logic u_s, u_z, u_ac, u_p, u_cy;
  pair_t sel; // pair_select_field
  assign busy = (state == S_RUN);
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ok = wr_fire && !busy;
  assign start = wr_ok && (aw_addr == `OFF_CMD) && w_strb[0] && (state == S_IDLE);
  assign done = busy && (cnt == op_states(op) - 5'h01);
  assign wr_af = wr_ok && (aw_addr == `OFF_AF);
  assign slot = cnt + 5'h01;
  assign sel = pair_t'(op[5:4]);
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq_enabled = ie;
  assign unpack_src = wr_af ? w_data[7:0] : tmp_lo;
  // pair select: code 3 names the status word, never the stack pointer
  always_comb begin
    case (sel)
      PAIR_BC: begin pair_hi = b; pair_lo = c; end
      PAIR_DE: begin pair_hi = d; pair_lo = e; end
      PAIR_HL: begin pair_hi = h; pair_lo = l; end
      default: begin pair_hi = acc; pair_lo = flag_byte; end
    endcase
  end
  flag_word_codec u_codec (
    .sign_in(fs),
    .zero_in(fz),
    .aux_in(fac),
    .parity_in(fp),
    .carry_in(fcy),
    .packed_byte(flag_byte),
    .unpack_byte(unpack_src),
    .sign_out(u_s),
    .zero_out(u_z),
    .aux_out(u_ac),
    .parity_out(u_p),
    .carry_out(u_cy)
  );
  // ****************************************
  // axi4-lite slave
  // ****************************************
  // write halves latch separately, answer after both are held
  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      // writes while busy are dropped but still answered
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_ok(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp = addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFF_CMD: next_rdata = {16'h0000, port, op};
        `OFF_STATUS: next_rdata = {27'h0000000, bad_op, ei_pend, ie, state == S_HALT, busy};
        `OFF_BC: next_rdata = {16'h0000, b, c};
        `OFF_DE: next_rdata = {16'h0000, d, e};
        `OFF_HL: next_rdata = {16'h0000, h, l};
        `OFF_AF: next_rdata = {16'h0000, acc, flag_byte};
        `OFF_SP: next_rdata = {16'h0000, sp};
        default: next_rdata = 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end
  // bus slave registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
  // ****************************************
  // executor
  // ****************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_op = op;
    next_port = port;
    {next_b, next_c, next_d, next_e, next_h, next_l, next_acc} = {b, c, d, e, h, l, acc};
    next_sp = sp;
    {next_fs, next_fz, next_fac, next_fp, next_fcy} = {fs, fz, fac, fp, fcy};
    next_ie = ie;
    next_ei_pend = ei_pend;
    next_bad_op = bad_op;
    next_tmp_lo = tmp_lo;
    next_tmp_hi = tmp_hi;
    next_bus_addr = bus_addr;
    next_data_out = data_out;
    {next_data_oe, next_mem_rd, next_mem_wr, next_io_rd, next_io_wr} = 5'h00;
    // register writes from software while idle or halted
    if (wr_ok) begin
      case (aw_addr)
        `OFF_BC: {next_b, next_c} = merge16({b, c}, w_data, w_strb);
        `OFF_DE: {next_d, next_e} = merge16({d, e}, w_data, w_strb);
        `OFF_HL: {next_h, next_l} = merge16({h, l}, w_data, w_strb);
        `OFF_SP: next_sp = merge16(sp, w_data, w_strb);
        `OFF_AF: begin
          next_acc = w_data[15:8];
          {next_fs, next_fz, next_fac, next_fp, next_fcy} = {u_s, u_z, u_ac, u_p, u_cy};
        end
        `OFF_STATUS: begin
          // writing one resumes a halt and clears the bad opcode mark
          if (w_data[`STAT_HALTED] && state == S_HALT) begin
            next_state = S_IDLE;
          end
          if (w_data[`STAT_BAD_OP]) begin
            next_bad_op = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_RUN;
          next_cnt = 5'h00;
          next_op = w_data[7:0];
          next_port = w_data[15:8];
          if (op_states(w_data[7:0]) == `ST_BAD) begin
            next_bad_op = 1'b1;
          end
        end
      end
      S_RUN: begin
        next_cnt = slot;
        // bus strobes for the coming state
        if (is_push(op) && slot == `SLOT_A) begin
          {next_mem_wr, next_data_oe} = 2'h3;
          next_bus_addr = sp - `ONE16;
          next_data_out = pair_hi;
        end else if (is_push(op) && slot == `SLOT_B) begin
          {next_mem_wr, next_data_oe} = 2'h3;
          next_bus_addr = sp - `SP_STEP;
          next_data_out = pair_lo;
        end else if ((is_pop(op) || op == `OP_SWAP_TOP) && (slot == `SLOT_A || slot == `SLOT_B)) begin
          next_mem_rd = 1'b1;
          next_bus_addr = (slot == `SLOT_A) ? sp : sp + `ONE16;
        end else if (op == `OP_SWAP_TOP && (slot == `SLOT_C || slot == `SLOT_D)) begin
          {next_mem_wr, next_data_oe} = 2'h3;
          next_bus_addr = (slot == `SLOT_C) ? sp + `ONE16 : sp;
          next_data_out = (slot == `SLOT_C) ? h : l;
        end else if ((op == `OP_IN || op == `OP_OUT) && slot == `SLOT_B) begin
          next_bus_addr = {port, port};
          next_io_rd = (op == `OP_IN);
          {next_io_wr, next_data_oe} = {2{op == `OP_OUT}};
          next_data_out = acc;
        end
        // capture read data in the strobe cycle
        if (mem_rd || io_rd) begin
          if (cnt == `SLOT_A || io_rd) begin
            next_tmp_lo = data_in;
          end else begin
            next_tmp_hi = data_in;
          end
        end
        if (done) begin
          next_state = S_IDLE;
          // a completed instruction releases a pending enable
          if (ei_pend) begin
            next_ie = 1'b1;
            next_ei_pend = 1'b0;
          end
          if (is_push(op)) begin
            next_sp = sp - `SP_STEP;
          end else if (is_pop(op)) begin
            next_sp = sp + `SP_STEP;
            case (sel)
              PAIR_BC: {next_b, next_c} = {tmp_hi, tmp_lo};
              PAIR_DE: {next_d, next_e} = {tmp_hi, tmp_lo};
              PAIR_HL: {next_h, next_l} = {tmp_hi, tmp_lo};
              default: begin
                // the only path that reloads flags during execution
                next_acc = tmp_hi;
                {next_fs, next_fz, next_fac, next_fp, next_fcy} = {u_s, u_z, u_ac, u_p, u_cy};
              end
            endcase
          end else begin
            case (op)
              `OP_SWAP_TOP: {next_h, next_l} = {tmp_hi, tmp_lo};
              `OP_LOAD_SP: next_sp = {h, l};
              `OP_IN: next_acc = tmp_lo;
              `OP_EI: next_ei_pend = 1'b1;
              `OP_DI: {next_ie, next_ei_pend} = 2'h0;
              `OP_STOP: next_state = S_HALT;
              default: begin
                // idle, output and unsupported codes leave state alone
              end
            endcase
          end
        end
      end
      S_HALT: begin
        // registers held until software resumes
      end
      default: next_state = S_IDLE;
    endcase
  end
  // executor registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      cnt <= 5'h00;
      op <= 8'h00;
      port <= 8'h00;
      {b, c, d, e, h, l, acc} <= 56'h0;
      sp <= 16'h0000;
      {fs, fz, fac, fp, fcy} <= 5'h00;
      ie <= 1'b0;
      ei_pend <= 1'b0;
      bad_op <= 1'b0;
      tmp_lo <= 8'h00;
      tmp_hi <= 8'h00;
      bus_addr <= 16'h0000;
      data_out <= 8'h00;
      {data_oe, mem_rd, mem_wr, io_rd, io_wr} <= 5'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      port <= next_port;
      {b, c, d, e, h, l, acc} <= {next_b, next_c, next_d, next_e, next_h, next_l, next_acc};
      sp <= next_sp;
      {fs, fz, fac, fp, fcy} <= {next_fs, next_fz, next_fac, next_fp, next_fcy};
      ie <= next_ie;
      ei_pend <= next_ei_pend;
      bad_op <= next_bad_op;
      tmp_lo <= next_tmp_lo;
      tmp_hi <= next_tmp_hi;
      bus_addr <= next_bus_addr;
      data_out <= next_data_out;
      {data_oe, mem_rd, mem_wr, io_rd, io_wr} <= {next_data_oe, next_mem_rd, next_mem_wr, next_io_rd, next_io_wr};
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_push_length: assert property (start && is_push(w_data[7:0]) |-> ##11 (done && is_push(op)))
    else $error("push did not finish in 11 states");
  a_push_sp_down: assert property (done && is_push(op) |=> sp == $past(sp) - `SP_STEP)
    else $error("push did not lower the stack pointer by two");
  a_status_byte: assert property (mem_wr && is_push(op) && sel == PAIR_STATUS && cnt == `SLOT_B
    |-> data_out == flag_byte && data_out[`FB_ONE1] && bus_addr == sp - `SP_STEP)
    else $error("status byte written wrong");
  a_pop_sp_up: assert property (done && is_pop(op) |=> sp == $past(sp) + `SP_STEP)
    else $error("pop did not raise the stack pointer by two");
  a_swap_length: assert property (start && w_data[7:0] == `OP_SWAP_TOP |-> ##18 (done && op == `OP_SWAP_TOP))
    else $error("swap did not take 18 states");
  a_load_sp: assert property (done && op == `OP_LOAD_SP |=> sp == {$past(h), $past(l)})
    else $error("stack pointer load wrong");
  a_out_drive: assert property (io_wr |-> data_oe && data_out == acc && bus_addr == {port, port})
    else $error("port output not driving accumulator");
  a_ei_delayed: assert property (done && op == `OP_EI && !ie && !ei_pend |=> !ie ##1 ei_pend)
    else $error("enable took effect too early");
  a_di_now: assert property (done && op == `OP_DI |=> !ie && !ei_pend)
    else $error("disable not immediate");
  a_halt_hold: assert property (state == S_HALT && !wr_ok |=> $stable(sp) && $stable(acc) && $stable(flag_byte))
    else $error("registers changed while halted");
  a_flags_source: assert property ($changed(flag_byte) |-> $past(wr_af) ||
    $past(done && is_pop(op) && sel == PAIR_STATUS))
    else $error("flags changed outside status pop");
endmodule

// ### bus_device_model.sv
// memory and port devices that answer the executor on its data bus
`timescale 1ns/1ps
module bus_device_model (
  // clock
  input wire logic clk,
  // bus from the executor
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic io_rd,
  input wire logic io_wr,
  // read data back to the executor
  output logic [7:0] data_in
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] mem [0:65535]; // byte memory, loaded by the bench
  logic [7:0] out_byte = 8'h00; // last byte sent to a port
  logic [7:0] out_port = 8'h00; // port of that byte
  logic [7:0] last = 8'h00; // last byte read back, inverted when idle
  // answers at once; an idle bus shows the inverse of the last byte
  always_comb begin
    if (mem_rd) begin
      data_in = mem[bus_addr];
    end else if (io_rd) begin
      data_in = bus_addr[7:0] ^ 8'h5A;
    end else begin
      data_in = ~last;
    end
  end
  // capture writes and remember the last read byte; plain always as the bench preloads mem
  always @(posedge clk) begin
    if (mem_rd || io_rd) begin
      last <= data_in;
    end
    if (mem_wr) begin
      mem[bus_addr] <= data_out;
    end
    if (io_wr && data_oe) begin
      out_byte <= data_out;
      out_port <= bus_addr[7:0];
    end
  end
endmodule

// ### test_stack_io_control_exec.sv
// self-checking bench for the stack, port and control executor
`timescale 1ns/1ps
module test_stack_io_control_exec;
  // ****************************************
  // signals and model state
  // ****************************************
  logic clk = 0;
  logic nrst = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp, rresp;
  logic [15:0] bus_addr, mr [5], sv [4]; // model: bc de hl af sp
  logic [7:0] data_in, data_out, p;
  logic data_oe, mem_rd, mem_wr, io_rd, io_wr, irq_enabled;
  int err_total = 0;
  int total_checks = 0;
  stack_io_exec stack_io_exec_i (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bus_addr, .data_in, .data_out, .data_oe, .mem_rd, .mem_wr, .io_rd, .io_wr, .irq_enabled);
  bus_device_model bus_device_model_i (.clk, .bus_addr, .data_out, .data_oe, .mem_rd, .mem_wr, .io_rd,
    .io_wr, .data_in);
  // clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // axi write, sampled at the falling edge to avoid races
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    bh = 0;
    while (!bh) begin
      @(negedge clk);
      ah = s_axi_awready && s_axi_awvalid;
      wh = s_axi_wready && s_axi_wvalid;
      bh = s_axi_bvalid;
      bresp = s_axi_bresp;
      @(posedge clk);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    @(posedge clk);
  endtask
  // axi read into rd and rresp
  task automatic rdr(input logic [31:0] a);
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    rh = 0;
    while (!rh) begin
      @(negedge clk);
      ah = s_axi_arready && s_axi_arvalid;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      rresp = s_axi_rresp;
      @(posedge clk);
      if (ah) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    @(posedge clk);
  endtask
  // start an instruction and poll busy until it clears
  task automatic ex(input logic [7:0] op, input logic [7:0] pt);
    wr(32'h0, {16'h0, pt, op});
    rd = 1;
    while (rd[0] !== 1'b0) rdr(32'h4);
  endtask
  // compare every pair and the stack pointer with the model
  task automatic check_all;
    for (int i = 0; i < 5; i++) begin
      rdr(32'(8 + 4 * i));
      chk(rd, {16'h0, mr[i]});
    end
  endtask
  // load random values into the first k registers
  task automatic rnd(input int k);
    for (int i = 0; i < k; i++) begin
      mr[i] = 16'($urandom);
      if (i == 3) mr[3][7:0] = (mr[3][7:0] & 8'hD5) | 8'h02;
      wr(32'(8 + 4 * i), {16'h0, mr[i]});
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(100 * 30000);
    err_total++;
    stop_test;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(63));
    repeat (20) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    chk(irq_enabled, 0);
    rdr(32'h40);
    chk(rd, 0);
    chk(rresp, 2'h2);
    wr(32'h40, 32'h1);
    chk(bresp, 2'h2);
    rnd(5);
    check_all;
    // push every pair code, then pop them back in reverse
    for (int r = 0; r < 4; r++) begin
      sv[r] = mr[r];
      ex(8'hC5 | {2'h0, 2'(r), 4'h0}, 8'h00);
      mr[4] = mr[4] - 16'h0002;
      chk(bus_device_model_i.mem[16'(mr[4] + 16'h0001)], sv[r][15:8]);
      chk(bus_device_model_i.mem[mr[4]], sv[r][7:0]);
      check_all;
    end
    rnd(4);
    for (int r = 3; r >= 0; r--) begin
      ex(8'hC1 | {2'h0, 2'(r), 4'h0}, 8'h00);
      mr[r] = sv[r];
      mr[4] = mr[4] + 16'h0002;
      check_all;
    end
    // swap stack top with the pointer pair
    sv[0] = 16'($urandom);
    bus_device_model_i.mem[mr[4]] = sv[0][7:0];
    bus_device_model_i.mem[16'(mr[4] + 16'h0001)] = sv[0][15:8];
    sv[1] = mr[2];
    ex(8'hE3, 8'h00);
    mr[2] = sv[0];
    chk(bus_device_model_i.mem[mr[4]], sv[1][7:0]);
    chk(bus_device_model_i.mem[16'(mr[4] + 16'h0001)], sv[1][15:8]);
    check_all;
    ex(8'hF9, 8'h00);
    mr[4] = mr[2];
    check_all;
    // port input then output
    p = 8'($urandom);
    ex(8'hDB, p);
    mr[3][15:8] = p ^ 8'h5A;
    check_all;
    p = p + 8'h01;
    ex(8'hD3, p);
    chk({bus_device_model_i.out_port, bus_device_model_i.out_byte}, {p, mr[3][15:8]});
    // interrupt enable waits one instruction, disable acts at once
    ex(8'hFB, 8'h00);
    chk(irq_enabled, 0);
    ex(8'h00, 8'h00);
    chk(irq_enabled, 1);
    ex(8'hF3, 8'h00);
    chk(irq_enabled, 0);
    // stop, resume, idle
    ex(8'h76, 8'h00);
    rdr(32'h4);
    chk(rd[1], 1);
    wr(32'h4, 32'h2);
    ex(8'h00, 8'h00);
    check_all;
    // unsupported opcode marks status bit 4 only
    ex(8'h07, 8'h00);
    rdr(32'h4);
    chk(rd[4:0], 5'h10);
    stop_test;
  end
endmodule
